// >>> wsp_watchdog.sv
// Watchdog counter that pauses and resumes around the STOP and HALT standby states.
module wsp_watchdog
	import wsp_pkg::*;
#(
	parameter int CNT_W = WSP_CNT_W
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ring_osc_clock,
	input wire logic x1_clock,
	input wire wsp_clk_stat_t clk_stat,
	input wire logic ring_stoppable,
	input wire logic wdt_src_sel,
	input wire logic wdt_stop,
	input wire logic [2:0] wdt_cycle_sel,
	input wire logic wdt_mode_reg_wr,
	input wire logic wdt_restart_key_reg_wr,
	input wire logic [7:0] wdt_restart_key_wdata,
	output logic [7:0] wdt_restart_key_reg,
	output logic [CNT_W-1:0] wdt_count,
	output logic wdt_counting,
	output logic wdt_overflow_rst
);
	// Count ticks from each source, resynchronised onto the system clock.
	logic ring_tick;
	logic x1_tick;

	wsp_tick_sync u_ring_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick_async(ring_osc_clock),
		.tick_pulse(ring_tick)
	);

	wsp_tick_sync u_x1_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick_async(x1_clock),
		.tick_pulse(x1_tick)
	);

	// Resume states after standby; the CPU source is latched at STOP entry.
	typedef enum logic [1:0] {WSP_RUN, WSP_STOPPED, WSP_WAIT_SETTLE, WSP_WAIT_EITHER} wsp_state_t;
	wsp_state_t state;
	wsp_state_t next_state;

	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	wsp_src_t src;
	wsp_src_t cpu_at_stop;
	logic [2:0] cycle;
	logic mode_written;
	logic rst_pulse;

	// A ring oscillator that cannot be stopped forces the ring source and no stop.
	wire wsp_src_t eff_src = ring_stoppable ? wsp_src_t'(wdt_src_sel) : WSP_SRC_RING;
	// Without a stoppable ring oscillator the count always runs on ring ticks.
	wire wsp_src_t cnt_src = ring_stoppable ? src : WSP_SRC_RING;
	wire stop_cfg = ring_stoppable & wdt_stop;
	wire stop_pause = clk_stat.stop_active & ring_stoppable;
	wire halt_pause = clk_stat.halt_active & ring_stoppable;
	wire cpu_x1 = (clk_stat.cpu_src == WSP_SRC_X1);
	wire run_ok = (state == WSP_RUN) & ~stop_pause & ~halt_pause & ~stop_cfg;
	wire tick = (cnt_src == WSP_SRC_X1) ? x1_tick : ring_tick;
	wire [4:0] ovf_exp = 5'(cycle) + ((cnt_src == WSP_SRC_X1) ? 5'(WSP_X1_BASE_EXP)
		: 5'(WSP_RING_BASE_EXP));
	wire [CNT_W-1:0] ovf_limit = (CNT_W'(1) << ovf_exp) - CNT_W'(1);
	wire key_ok = (wdt_restart_key_wdata == WSP_RESTART_KEY);
	wire restart = wdt_restart_key_reg_wr & key_ok;
	wire bad_access = ~stop_cfg & ((wdt_restart_key_reg_wr & ~key_ok)
		| (wdt_mode_reg_wr & mode_written));
	wire overflow = run_ok & tick & (count >= ovf_limit);

	// Resume decision per clock pair at STOP release.
	always_comb
	begin
		next_state = state;
		case (state)
			WSP_RUN:
				if (stop_pause)
					next_state = WSP_STOPPED;
			WSP_STOPPED:
				if (!stop_pause)
				begin
					if (src == WSP_SRC_RING)
						next_state = WSP_RUN;
					else if (cpu_at_stop == WSP_SRC_X1)
						next_state = WSP_WAIT_SETTLE;
					else
						next_state = WSP_WAIT_EITHER;
				end
			WSP_WAIT_SETTLE:
				if (clk_stat.settle_done)
					next_state = WSP_RUN;
			WSP_WAIT_EITHER:
				if (clk_stat.settle_done || cpu_x1)
					next_state = WSP_RUN;
			default:
				next_state = WSP_RUN;
		endcase
		if (stop_pause)
			next_state = WSP_STOPPED;
	end

	// Restart and mode writes clear; pauses hold the count rather than zeroing it.
	always_comb
	begin
		next_count = count;
		if (restart || wdt_mode_reg_wr || overflow)
			next_count = '0;
		else if (run_ok && tick)
			next_count = count + CNT_W'(1);
	end

	// Mode writes take the source and cycle; a pause keeps the previous source.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src <= WSP_SRC_RING;
			cycle <= WSP_CYCLE_RESET;
			mode_written <= 1'b0;
		end
		else if (wdt_mode_reg_wr)
		begin
			src <= eff_src;
			cycle <= wdt_cycle_sel;
			mode_written <= 1'b1;
		end
	end

	// Counter, resume state and the CPU source captured on STOP entry.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count <= '0;
			state <= WSP_RUN;
			cpu_at_stop <= WSP_SRC_RING;
			rst_pulse <= 1'b0;
		end
		else
		begin
			count <= next_count;
			state <= next_state;
			if (stop_pause && state != WSP_STOPPED)
				cpu_at_stop <= clk_stat.cpu_src;
			rst_pulse <= overflow | bad_access;
		end
	end

	// The restart register always reads back its fixed pattern, not the key.
	assign wdt_restart_key_reg = WSP_RESTART_READ;
	assign wdt_count = count;
	assign wdt_counting = run_ok;
	assign wdt_overflow_rst = rst_pulse;

	// Named steps of the STOP release in the X1/X1 case.
	sequence s_stop_x1x1;
		state == WSP_STOPPED && !stop_pause && src == WSP_SRC_X1 && cpu_at_stop == WSP_SRC_X1;
	endsequence

	a_stop_freezes_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stop_pause && !restart && !wdt_mode_reg_wr |=> $stable(count))
		else $error("Count moved during STOP.");
	a_halt_freezes_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
		halt_pause && !restart && !wdt_mode_reg_wr |=> $stable(count))
		else $error("Count moved during HALT.");
	a_x1x1_waits_settle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_stop_x1x1 ##1 (!clk_stat.settle_done && !stop_pause) |=> !wdt_counting)
		else $error("Counting resumed before settling in X1 case.");
	a_ring_resume_now: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == WSP_STOPPED && !stop_pause && src == WSP_SRC_RING |=> state == WSP_RUN)
		else $error("Ring source did not resume at once.");
	a_either_resume: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == WSP_WAIT_EITHER && !stop_pause && (clk_stat.settle_done || cpu_x1)
		|=> state == WSP_RUN)
		else $error("Resume not taken at earlier event.");
	a_pause_keeps_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == WSP_STOPPED && !stop_pause && !restart && !wdt_mode_reg_wr
		|=> count == $past(count))
		else $error("Count lost at standby release.");
	a_nostop_counts: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ring_stoppable && state == WSP_RUN |-> wdt_counting)
		else $error("Fixed ring config stopped counting.");
	a_restart_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
		restart |=> count == '0)
		else $error("Restart key did not clear the count.");
	a_overflow_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		overflow |=> wdt_overflow_rst)
		else $error("Overflow gave no internal reset.");

	// Entry into STOP and the idle wait for either resume event, as named steps.
	sequence s_stop_entry;
		state == WSP_RUN && stop_pause;
	endsequence

	sequence s_either_idle;
		state == WSP_WAIT_EITHER && !clk_stat.settle_done && !cpu_x1;
	endsequence

	a_stop_entry_halts: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_stop_entry |=> state == WSP_STOPPED && !wdt_counting)
		else $error("STOP entry did not pause the counter.");
	a_settle_resume: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == WSP_WAIT_SETTLE && clk_stat.settle_done && !stop_pause
		|=> state == WSP_RUN)
		else $error("Counting did not resume when settling ended.");
	a_either_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_either_idle |=> !wdt_counting)
		else $error("Counting resumed before either resume event.");
	// A rejected write must end in the internal reset unless the counter is stopped.
	a_bad_key_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wdt_restart_key_reg_wr && !key_ok && !stop_cfg |=> wdt_overflow_rst)
		else $error("Wrong restart key gave no internal reset.");
	a_mode_twice_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wdt_mode_reg_wr && mode_written && !stop_cfg |=> wdt_overflow_rst)
		else $error("Second mode write gave no internal reset.");
	// The halt pause is lifted in the same cycle as the controller drops its flag.
	a_halt_resume: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == WSP_RUN && $fell(halt_pause) && !stop_pause && !stop_cfg |-> wdt_counting)
		else $error("Counting did not continue after HALT release.");
endmodule // wsp_watchdog

// >>> wsp_pkg.sv
// Package of constants and carrier types for the watchdog standby pause block.
// Overview of operation
// - Counter freezes during STOP whichever clock drives it.
// - CPU and counter on X1: stay frozen after STOP until settling ends.
// - CPU on X1, counter on ring oscillator: resume right after STOP release.
// - CPU on ring, counter on X1: resume at settle end or CPU switch to X1.
// - Both on ring oscillator: resume immediately after STOP release.
// - Resuming keeps the count reached before the pause.
// - Counter freezes during HALT for every clock combination if the ring oscillator can stop, then continues.
// - If ring oscillator cannot stop, counting continues through STOP.
// - Writing the restart key clears the count and restarts counting.
// - Counter overflow asserts the internal reset, also after standby resume.
package wsp_pkg;
	localparam logic [7:0] WSP_RESTART_KEY = 8'hac;
	localparam logic [7:0] WSP_RESTART_READ = 8'h9a;
	localparam logic [2:0] WSP_CYCLE_RESET = 3'h7;
	localparam int WSP_CNT_W = 21;
	localparam int WSP_RING_BASE_EXP = 11;
	localparam int WSP_X1_BASE_EXP = 13;

	// Clock source encoding shared by the CPU clock and the counter clock.
	typedef enum logic {WSP_SRC_RING, WSP_SRC_X1} wsp_src_t;

	// Standby and clock status delivered by the clock controller.
	typedef struct packed {
		logic stop_active;
		logic halt_active;
		logic settle_done;
		wsp_src_t cpu_src;
	} wsp_clk_stat_t;
endpackage

// >>> wsp_tick_sync.sv
// Two-stage synchroniser with a rising-edge pulse for one count tick input.
module wsp_tick_sync
	import wsp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tick_async,
	output logic tick_pulse
);
	logic meta;
	logic sync;
	logic sync_d;

	// Only the second stage feeds the edge detector, the first is never looked at.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			sync_d <= 1'b0;
		end
		else
		begin
			meta <= tick_async;
			sync <= meta;
			sync_d <= sync;
		end
	end

	assign tick_pulse = sync & ~sync_d;
endmodule // wsp_tick_sync

// >>> wsp_clk_model.sv
// Clock controller model: standby flags, settle pulse, CPU source and slow clocks.
module wsp_clk_model
	import wsp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic stop_req,
	input wire logic halt_req,
	input wire logic cpu_x1,
	output wsp_clk_stat_t clk_stat,
	output logic ring_osc_clock,
	output logic x1_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] div;
	logic [3:0] settle;
	// Both oscillators run slowly; a restart of X1 needs 15 cycles to settle.
	assign ring_osc_clock = div[3];
	assign x1_clock = div[2];
	// Status is registered, as a real controller would present it.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div <= 4'h0;
			settle <= 4'h0;
			clk_stat <= '0;
		end
		else
		begin
			div <= div + 4'h1;
			settle <= (clk_stat.stop_active && !stop_req) ? 4'hf : settle - {3'h0, |settle};
			clk_stat.stop_active <= stop_req;
			clk_stat.halt_active <= halt_req;
			clk_stat.settle_done <= (settle == 4'h1);
			clk_stat.cpu_src <= wsp_src_t'(cpu_x1);
		end
	end
endmodule // wsp_clk_model

// >>> watchdog_standby_pause_tb_top.sv
// Self-checking bench for the watchdog standby pause block.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module watchdog_standby_pause_tb_top
	import wsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, rst_n = 1'b0, ring_stoppable = 1'b1, wdt_src_sel = 1'b0;
	logic wdt_stop = 1'b0, wdt_mode_reg_wr = 1'b0, wdt_restart_key_reg_wr = 1'b0;
	logic stop_req = 1'b0, halt_req = 1'b0, cpu_x1 = 1'b0;
	logic [2:0] wdt_cycle_sel = 3'h0;
	logic [7:0] wdt_restart_key_wdata = 8'h00, wdt_restart_key_reg;
	logic [WSP_CNT_W-1:0] wdt_count, c;
	logic ring_osc_clock, x1_clock, wdt_counting, wdt_overflow_rst;
	wsp_clk_stat_t clk_stat;
	int failures = 0, samples_checked = 0, n;
	always #20 clk_sys = ~clk_sys;
	wsp_clk_model cc (.clk_sys(clk_sys), .rst_n(rst_n), .stop_req(stop_req),
		.halt_req(halt_req), .cpu_x1(cpu_x1), .clk_stat(clk_stat),
		.ring_osc_clock(ring_osc_clock), .x1_clock(x1_clock));
	wsp_watchdog #(.CNT_W(WSP_CNT_W)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
		.ring_osc_clock(ring_osc_clock), .x1_clock(x1_clock), .clk_stat(clk_stat),
		.ring_stoppable(ring_stoppable), .wdt_src_sel(wdt_src_sel), .wdt_stop(wdt_stop),
		.wdt_cycle_sel(wdt_cycle_sel), .wdt_mode_reg_wr(wdt_mode_reg_wr),
		.wdt_restart_key_reg_wr(wdt_restart_key_reg_wr),
		.wdt_restart_key_wdata(wdt_restart_key_wdata),
		.wdt_restart_key_reg(wdt_restart_key_reg), .wdt_count(wdt_count),
		.wdt_counting(wdt_counting), .wdt_overflow_rst(wdt_overflow_rst));
	// Inputs always change a fixed 2 ns after the rising edge.
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#2;
	endtask
	task automatic end_sim;
		if (failures == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Reset, then the single mode write that this reset allows.
	task automatic start(input logic src);
		rst_n = 1'b0;
		cyc(16);
		rst_n = 1'b1;
		cyc(1);
		wdt_src_sel = src;
		wdt_mode_reg_wr = 1'b1;
		cyc(1);
		wdt_mode_reg_wr = 1'b0;
		cyc(200);
	endtask
	// One STOP episode; wt says whether counting must wait for settling.
	task automatic st(input logic cpu, input logic wt);
		cpu_x1 = cpu;
		stop_req = 1'b1;
		cyc(6);
		c = wdt_count;
		`CHK(wdt_counting, 1'b0)
		cyc(40);
		`CHK(wdt_count, c)
		stop_req = 1'b0;
		cyc(5);
		`CHK(wdt_counting, !wt)
		cyc(40);
		`CHK(wdt_count > c, 1'b1)
	endtask
	// Main sequence: ring source first, then X1 source after a fresh reset.
	initial
	begin
		start(1'b0);
		`CHK(wdt_restart_key_reg, 8'h9a)
		st(1'b0, 1'b0);
		st(1'b1, 1'b0);
		halt_req = 1'b1;
		cyc(6);
		c = wdt_count;
		`CHK(wdt_counting, 1'b0)
		cyc(40);
		`CHK(wdt_count, c)
		halt_req = 1'b0;
		cyc(40);
		`CHK(wdt_count > c, 1'b1)
		wdt_restart_key_wdata = WSP_RESTART_KEY;
		wdt_restart_key_reg_wr = 1'b1;
		cyc(1);
		wdt_restart_key_reg_wr = 1'b0;
		cyc(1);
		`CHK(wdt_count < 21'h2, 1'b1)
		// The shortest ring cycle is 2^11 ticks of 16 system clocks each.
		n = 0;
		while (wdt_overflow_rst !== 1'b1 && n < 40000)
		begin
			cyc(1);
			n++;
		end
		`CHK(n > 32700 && n < 32830, 1'b1)
		start(1'b1);
		st(1'b1, 1'b1);
		st(1'b0, 1'b1);
		stop_req = 1'b1;
		cyc(6);
		stop_req = 1'b0;
		cyc(3);
		cpu_x1 = 1'b1;
		cyc(4);
		`CHK(wdt_counting, 1'b1)
		// A wrong key is ignored while the counter is stopped, and resets it otherwise.
		wdt_stop = 1'b1;
		wdt_restart_key_wdata = 8'h00;
		wdt_restart_key_reg_wr = 1'b1;
		cyc(1);
		`CHK(wdt_counting, 1'b0)
		`CHK(wdt_overflow_rst, 1'b0)
		wdt_stop = 1'b0;
		cyc(1);
		`CHK(wdt_overflow_rst, 1'b1)
		wdt_restart_key_reg_wr = 1'b0;
		cyc(1);
		`CHK(wdt_overflow_rst, 1'b0)
		wdt_mode_reg_wr = 1'b1;
		cyc(1);
		wdt_mode_reg_wr = 1'b0;
		`CHK(wdt_overflow_rst, 1'b1)
		ring_stoppable = 1'b0;
		stop_req = 1'b1;
		cyc(8);
		`CHK(wdt_counting, 1'b1)
		c = wdt_count;
		cyc(40);
		`CHK(wdt_count > c, 1'b1)
		end_sim();
	end
	// Watchdog against a hang, well beyond the expected run length.
	initial
	begin
		repeat (90000) @(posedge clk_sys);
		failures++;
		end_sim();
	end
endmodule // watchdog_standby_pause_tb_top
